/* mps_panel.sv */
// maintenance panel, buffer walk, refresh and sense/status
// assumes synchronous panel inputs and an APB master
`timescale 1ns/10ps
`include "mps_params.svh"
module mps_panel #(
   parameter int AW         = 12,                             // buffer address bits
   parameter int STROKES    = 8,                              // strokes per glyph
   parameter int TP_N       = 16,                             // sequencer pulses
   parameter int DEB_CYCLES = `MPS_DEB_US * `MPS_CLK_MHZ      // debounce hold
) (
   input  wire logic                   pclk,        // machine clock
   input  wire logic                   presetn,     // async reset
   input  wire logic                   psel,        // apb select
   input  wire logic                   penable,     // apb enable
   input  wire logic                   pwrite,      // apb direction
   input  wire logic [11:0]            paddr,       // apb address
   input  wire logic [31:0]            pwdata,      // apb write data
   output logic      [31:0]            prdata,      // apb read data
   output logic                        pready,      // apb ready
   output logic                        pslverr,     // apb error
   input  wire mps_pkg::mps_button_type buttons,    // pushbuttons
   input  wire mps_pkg::mps_switch_type switches,   // panel levels
   input  wire mps_pkg::mps_event_type  events,     // machine state
   output logic      [9:0]             lamps_hi,    // indicator bank 1
   output logic      [9:0]             lamps_lo,    // indicator bank 2
   output logic      [6:0]             feature_on,  // enabled features
   output logic      [4:0]             tp_index,    // sequencer pulse
   output logic                        tp_pulse,    // sequencer fire
   output logic      [7:0]             glyph_code,  // char generator code
   output logic      [2:0]             glyph_stroke,// current stroke
   output logic                        check_stop,  // parity halt
   output logic                        power_on,    // power sequencing
   output logic      [7:0]             cmd_decode   // decoder input
);
   import mps_pkg::*;

   // debounce bank: one pulse per settled press and release
   logic [7:0] btn_raw, btn_level, btn_press, btn_rel;
   assign btn_raw = buttons;
   for (genvar g = 0; g < 8; g++) begin : g_deb
      logic [$clog2(DEB_CYCLES+1)-1:0] cnt;
      logic                            last;
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt  <= '0;
            last <= 1'b0;
         end else if (btn_raw[g] == btn_level[g]) begin
            cnt  <= '0;
            last <= btn_level[g];
         end else if (cnt == ($clog2(DEB_CYCLES+1))'(DEB_CYCLES - 1)) begin
            cnt  <= '0;
            last <= btn_level[g];
         end else begin
            cnt  <= cnt + 1'b1;
            last <= btn_level[g];
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) btn_level[g] <= 1'b0;
         else if (btn_raw[g] != btn_level[g] &&
                  cnt == ($clog2(DEB_CYCLES+1))'(DEB_CYCLES - 1)) btn_level[g] <= btn_raw[g];
      end
      assign btn_press[g] = btn_level[g] & ~last;
      assign btn_rel[g]   = ~btn_level[g] & last;
   end

   // gating: clear, lamp test, option switches, rotary and the power buttons and power switch bypass the key
   wire svc_ok   = events.machine_disabled & switches.key_service;
   wire clr      = btn_press[4];
   wire opt_buf  = switches.options[`MPS_OPT_BUF];
   wire opt_chr  = switches.options[`MPS_OPT_CHAR];
   wire opt_pen  = switches.options[`MPS_OPT_PEN];
   wire do_enter = svc_ok & btn_press[0];
   wire do_step  = svc_ok & btn_press[1];
   wire do_peek  = svc_ok & opt_buf & btn_press[2];
   wire do_back  = svc_ok & opt_buf & btn_rel[2];
   wire do_strk  = svc_ok & opt_chr & btn_press[3];
   wire do_one   = svc_ok & opt_buf & btn_press[7];
   wire do_cont  = svc_ok & opt_buf & switches.regen_cont;
   wire do_rep   = svc_ok & opt_chr & switches.glyph_repeat;
   wire free_run = ~svc_ok | switches.free_run;

   // buffer words: cursor, parity, data
   logic [9:0]    buf_mem [0:(1<<AW)-1];
   logic [AW-1:0] bac;
   logic [8:0]    reg_b;
   logic [7:0]    reg_a;
   logic          cur_b;
   mps_regen_type regen, next_regen;
   logic          regen_single;
   wire  [9:0]    buf_word = buf_mem[bac];
   wire           buf_perr = ~^buf_word[8:0];     // odd parity expected
   wire           b_perr   = ~^reg_b;
   wire           regen_run = (regen == MPS_RUN);
   wire           halt_hit = tp_pulse & regen_run & (buf_word[7:0] == `MPS_HALT_CODE);
   wire           ld_buf = do_enter & (switches.load_target == `MPS_LOAD_BUF);
   wire           ld_reg = do_enter & (switches.load_target == `MPS_LOAD_REG);
   wire           ld_hi  = do_enter & (switches.load_target == `MPS_LOAD_HI);
   wire           ld_lo  = do_enter & (switches.load_target == `MPS_LOAD_LO);
   wire           rd_step = tp_pulse & regen_run;

   // sequencer: free run at clock rate, else one pulse per step
   assign tp_pulse = ~check_stop & (free_run | do_step);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tp_index <= '0;
      else if (clr) tp_index <= '0;
      else if (tp_pulse) tp_index <= (tp_index == 5'(TP_N - 1)) ? '0 : tp_index + 1'b1;
   end

   // buffer writes from enter and peek release
   always_ff @(posedge pclk) begin
      if (ld_buf) buf_mem[bac] <= {switches.cursor_bit, switches.bus_out};
      else if (do_back) buf_mem[bac] <= {cur_b, reg_b};
   end

   // address counter: manual load, stepping after buffer access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bac <= '0;
      else if (clr) bac <= '0;
      else if (ld_hi) bac <= {switches.bus_out[AW-9:0], bac[7:0]};
      else if (ld_lo) bac <= {bac[AW-1:8], switches.bus_out[7:0]};
      else if (ld_buf | do_back | rd_step) bac <= bac + 1'b1;
   end

   // holding registers A and B
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_a <= '0;
         reg_b <= 9'h100;
         cur_b <= 1'b0;
      end else if (clr) begin
         reg_a <= '0;
         reg_b <= 9'h100;
         cur_b <= 1'b0;
      end else if (ld_reg) begin
         reg_a <= switches.bus_out[7:0];
         reg_b <= switches.bus_out;
         cur_b <= switches.cursor_bit;
      end else if (do_peek | rd_step) begin
         reg_b <= buf_word[8:0];
         cur_b <= buf_word[9];
      end
   end

   // refresh control
   always_comb begin
      next_regen = regen;
      unique case (regen)
         MPS_IDLE: if (do_one | do_cont) next_regen = MPS_RUN;
         MPS_RUN:  if (halt_hit & (regen_single | ~do_cont)) next_regen = MPS_STOP;
         MPS_STOP: next_regen = MPS_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regen        <= MPS_IDLE;
         regen_single <= 1'b0;
      end else if (clr) begin
         regen        <= MPS_IDLE;
         regen_single <= 1'b0;
      end else begin
         regen <= next_regen;
         if (regen == MPS_IDLE) regen_single <= do_one;
      end
   end

   // check stop on B parity unless bypassed off-line
   wire bypass = switches.parity_override & svc_ok & events.offline;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) check_stop <= 1'b0;
      else if (clr) check_stop <= 1'b0;
      else if (b_perr & ~bypass) check_stop <= 1'b1;
   end

   // character generator strokes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) glyph_stroke <= '0;
      else if (clr) glyph_stroke <= '0;
      else if ((do_rep & tp_pulse) | do_strk)
         glyph_stroke <= (glyph_stroke == 3'(STROKES - 1)) ? '0 : glyph_stroke + 1'b1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) glyph_code <= '0;
      else glyph_code <= reg_a;
   end

   // power sequencing source
   logic power_local;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) power_local <= 1'b0;
      else if (btn_press[5]) power_local <= 1'b1;
      else if (btn_press[6]) power_local <= 1'b0;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) power_on <= 1'b0;
      else power_on <= switches.power_remote ? events.power_contact : power_local;
   end

   // apb decode; slave always answers in the access cycle
   wire       acc    = psel & penable;
   wire       sel_er = paddr == `MPS_OFF_ERR;
   wire       sel_md = paddr == `MPS_OFF_MODE;
   wire       sel_st = paddr == `MPS_OFF_STAT;
   wire       sel_cm = paddr == `MPS_OFF_CMD;
   wire       sel_vw = paddr == `MPS_OFF_VIEW;
   wire       mapped = sel_er | sel_md | sel_st | sel_cm | sel_vw;
   wire       rd_er  = acc & ~pwrite & sel_er;
   wire       rd_md  = acc & ~pwrite & sel_md;
   wire       rd_st  = acc & ~pwrite & sel_st;
   wire       wr_cm  = acc & pwrite & sel_cm;
   assign pready  = 1'b1;
   assign pslverr = acc & (~mapped | (pwrite & ~sel_cm));

   // command register and its checks
   logic [7:0] err_sense, mode_sense, unit_status;
   wire        cmd_par_bad = wr_cm & ~^pwdata[8:0];
   wire        cmd_bad_mod = wr_cm & (pwdata[1:0] == 2'b00);
   wire        cmd_bad_seq = wr_cm & ~unit_status[`MPS_B_ST_FREE];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cmd_decode <= '0;
      else if (clr) cmd_decode <= '0;
      else if (wr_cm) cmd_decode <= pwdata[7:0];
   end

   // sticky sense and status except status busy and free, set wins over read clear
   wire pen_ev = events.pen_hit & opt_pen;
   wire end_ev = halt_hit;
   wire buf_er = (do_peek | rd_step) & buf_perr;
   wire [7:0] err_set  = {1'b0, regen_run, 1'b0, buf_er, 1'b0, cmd_par_bad,
                          1'b0, cmd_bad_mod | cmd_bad_seq};
   wire [7:0] mode_set = {5'h00, events.char_mode, end_ev, pen_ev};
   wire       any_err  = |err_set[4:0];
   wire       pend     = |err_sense | |mode_sense;
   wire [7:0] st_set   = {1'b0, any_err | pen_ev | end_ev,
                          1'b0, wr_cm, pend, 2'b00,
                          events.service_req | end_ev | (buf_er & regen_run)};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_sense   <= '0;
         mode_sense  <= '0;
         unit_status <= 8'h20;
      end else if (clr) begin
         err_sense   <= '0;
         mode_sense  <= '0;
         unit_status <= 8'h20;
      end else begin
         err_sense   <= err_set  | (rd_er ? 8'h00 : err_sense);
         mode_sense  <= mode_set | (rd_md ? 8'h00 : mode_sense);
         unit_status[7:6] <= st_set[7:6] | (rd_st ? 2'b00 : unit_status[7:6]);
         unit_status[4:0] <= st_set[4:0] | (rd_st ? 5'h00 : unit_status[4:0]);
         unit_status[`MPS_B_ST_BUSY] <= pend | (|unit_status[2:0]);
         if (wr_cm) unit_status[`MPS_B_ST_FREE] <= 1'b0;
         else if (~regen_run) unit_status[`MPS_B_ST_FREE] <= 1'b1;
      end
   end

   // read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= '0;
      else if (psel & ~penable & ~pwrite)
         prdata <= sel_er ? {24'h0, err_sense}  :
                   sel_md ? {24'h0, mode_sense} :
                   sel_st ? {24'h0, unit_status} :
                   sel_cm ? {24'h0, cmd_decode} :
                   sel_vw ? {reg_b[7:0], reg_a, 4'h0, 12'(bac)} : 32'h0;
   end

   // indicator routing through the rotary switches.rotary
   logic [19:0] lamp_mux;
   always_comb begin
      lamp_mux = '0;
      unique case (switches.rotary)
         3'd0: lamp_mux = {2'b00, cmd_decode, 1'b0, switches.bus_out};
         3'd1: lamp_mux = {1'b0, reg_b, 2'b00, reg_a};
         3'd2: lamp_mux = {cur_b, reg_b, 10'h000};
         3'd3: lamp_mux = {12'h000, glyph_code};
         3'd4: lamp_mux = {8'h00, 12'(bac)};
         3'd5: lamp_mux = {buf_word, 10'h000};
         3'd6: lamp_mux = {err_sense, 2'b00, mode_sense, 2'b00};
         3'd7: lamp_mux = {unit_status, 7'h00, regen, 2'b00};
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamps_hi   <= '0;
         lamps_lo   <= '0;
         feature_on <= '0;
      end else begin
         lamps_hi   <= switches.lamp_test ? 10'h3FF : lamp_mux[19:10];
         lamps_lo   <= switches.lamp_test ? 10'h3FF : lamp_mux[9:0];
         feature_on <= switches.options;
      end
   end

   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   gate_enter_a: assert property (ld_buf |-> svc_ok)
      else $error("enter acted without service gating");
   clear_all_a: assert property (clr |=> bac == '0 && check_stop == 1'b0 && regen == MPS_IDLE)
      else $error("system clear left state");
   load_hi_a: assert property (ld_hi |=> bac[AW-1:8] == $past(switches.bus_out[AW-9:0]))
      else $error("high address load wrong");
   peek_back_a: assert property (do_back & ~clr |=> bac == $past(bac) + 1'b1)
      else $error("peek release did not step address");
   seq_free_a: assert property (free_run & ~check_stop & ~clr |-> tp_pulse)
      else $error("free run sequencer stalled");
   single_halt_a: assert property (regen_run & regen_single & halt_hit & ~clr
                                   |=> regen == MPS_STOP ##1 regen == MPS_IDLE)
      else $error("single refresh did not halt");
   bypass_a: assert property (b_perr & ~bypass & ~clr |=> check_stop)
      else $error("parity did not stop");
   bus_par_a: assert property (cmd_par_bad & ~clr |=> err_sense[`MPS_B_ERR_BUS])
      else $error("bus parity not flagged");
   sticky_a: assert property (pen_ev & ~clr |=> mode_sense[0] && unit_status[6])
      else $error("pen hit not recorded");
   run_bit_a: assert property (regen_run & ~clr |=> err_sense[`MPS_B_ERR_RUN])
      else $error("running bit missing");
   lamp_a: assert property (switches.lamp_test |=> lamps_hi == 10'h3FF)
      else $error("lamp test failed");
   cov_regen_c: cover property (regen_run ##[1:20] regen == MPS_STOP);
   cov_peek_c: cover property (do_peek ##[1:50] do_back);
   cov_cmd_c: cover property (wr_cm ##1 rd_st);
endmodule : mps_panel

/* mps_params.svh */
// constants for the maintenance panel and sense/status block
// assumes a 20 MHz pclk and an APB master with 32-bit data
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
`define MPS_OFF_ERR    12'h000
`define MPS_OFF_MODE   12'h004
`define MPS_OFF_STAT   12'h008
`define MPS_OFF_CMD    12'h00C
`define MPS_OFF_VIEW   12'h010
`define MPS_CLK_MHZ    20
`define MPS_DEB_US     2000
`define MPS_HALT_CODE  8'hFF
`define MPS_LOAD_HI    2'h0
`define MPS_LOAD_LO    2'h1
`define MPS_LOAD_BUF   2'h2
`define MPS_LOAD_REG   2'h3
`define MPS_OPT_BUF    0
`define MPS_OPT_CHAR   1
`define MPS_OPT_PEN    2
`define MPS_B_ERR_CMD  0
`define MPS_B_ERR_BUS  2
`define MPS_B_ERR_DATA 4
`define MPS_B_ERR_RUN  6
`define MPS_B_MOD_PEN  0
`define MPS_B_MOD_END  1
`define MPS_B_MOD_CHR  2
`define MPS_B_ST_ATN   0
`define MPS_B_ST_BUSY  3
`define MPS_B_ST_XFER  4
`define MPS_B_ST_FREE  5
`define MPS_B_ST_FLT   6
`endif

/* mps_pkg.sv */
// types for the maintenance panel and sense/status block
// assumes mps_params.svh supplies the numeric constants
package mps_pkg;
   // panel pushbuttons, index order of the debounce bank
   typedef struct packed {
      logic regen_one;  // single refresh start
      logic pwr_off;    // console power off
      logic pwr_on;     // console power on
      logic clear;      // system clear
      logic stroke;     // stroke step
      logic peek;       // buffer peek
      logic step;       // sequencer step
      logic enter;      // enter
   } mps_button_type;
   // panel levels
   typedef struct packed {
      logic       lamp_test;
      logic       key_service;
      logic       cursor_bit;
      logic       free_run;
      logic       regen_cont;
      logic       parity_override;
      logic       glyph_repeat;
      logic       power_remote;
      logic [1:0] load_target;
      logic [2:0] rotary;
      logic [6:0] options;
      logic [8:0] bus_out;
   } mps_switch_type;
   // machine conditions
   typedef struct packed {
      logic machine_disabled;
      logic offline;
      logic pen_hit;
      logic service_req;
      logic char_mode;
      logic power_contact;
   } mps_event_type;
   typedef enum logic [2:0] {
      MPS_IDLE = 3'b001,
      MPS_RUN  = 3'b010,
      MPS_STOP = 3'b100
   } mps_regen_type;
endpackage : mps_pkg

/* mps_panel_model.sv */
// panel-side partner: pushbutton presses seen by the panel block
// assumes the bench calls press() and a short debounce parameter
`timescale 1ns/10ps
module mps_panel_model #(
   parameter int HOLD = 12                  // cycles each level is held
) (
   input  wire logic               pclk,    // machine clock
   output mps_pkg::mps_button_type buttons  // pushbutton levels
);
   import mps_pkg::*;
   initial buttons = '0;
   // hold both levels well past the debounce so one press counts once
   task automatic press(input int idx);
      @(posedge pclk);
      buttons[idx] <= 1'b1;
      repeat (HOLD) @(posedge pclk);
      buttons[idx] <= 1'b0;
      repeat (HOLD) @(posedge pclk);
   endtask : press
endmodule : mps_panel_model

/* tb.sv */
// self-checking bench for the maintenance panel and sense/status block
// assumes mps_pkg, mps_params.svh and the panel model are compiled first
`timescale 1ns/10ps
`include "mps_params.svh"
module tb;
   import mps_pkg::*;
   logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0]    paddr = '0;
   logic [31:0]    pwdata = '0, prdata, rd;
   logic           pready, pslverr, tp_pulse, power_on, err, check_stop;
   logic [4:0]     tp_index;
   logic [2:0]     glyph_stroke;
   logic [7:0]     glyph_code;
   logic [9:0]     lamps_hi, lamps_lo;
   logic [6:0]     feature_on;
   logic [7:0]     cmd_decode;
   mps_button_type buttons;
   mps_switch_type sw = '0;
   mps_event_type  ev = '0;
   int             fails = 0, n_tests = 0, tp_cnt = 0;
   // 20 MHz machine clock
   always #25 pclk = ~pclk;
   // short debounce keeps presses to a few dozen cycles
   mps_panel #(.DEB_CYCLES(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .buttons(buttons), .switches(sw), .events(ev), .lamps_hi(lamps_hi), .lamps_lo(lamps_lo),
      .feature_on(feature_on), .tp_index(tp_index), .tp_pulse(tp_pulse), .glyph_code(glyph_code),
      .glyph_stroke(glyph_stroke), .check_stop(check_stop), .power_on(power_on), .cmd_decode(cmd_decode));
   mps_panel_model pm_u (.pclk(pclk), .buttons(buttons));
   // count sequencer pulses for the stepping check
   always @(posedge pclk) if (tp_pulse === 1'b1) tp_cnt <= tp_cnt + 1;
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // one APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         fails++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_reset();
      apb(0, 12'h008, '0);
      chk("status", rd, 32'h20);
      apb(0, 12'h000, '0);
      chk("error", rd, 32'h0);
      apb(1, 12'h000, 32'hFF);
      chk("ro_write", err, 1);
      apb(0, 12'h020, '0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      $display("test reset done");
   endtask : t_reset
   // good command, then bad modifier and bad parity
   task automatic t_cmd();
      apb(1, 12'h00C, 32'h001);
      repeat (2) @(posedge pclk);
      chk("cmd", cmd_decode, 32'h01);
      apb(0, 12'h008, '0);
      chk("free", rd[5], 1);
      apb(1, 12'h00C, 32'h004);
      apb(1, 12'h00C, 32'h101);
      apb(0, 12'h008, '0);
      chk("fault_busy", {rd[6], rd[3]}, 2'b11);
      apb(0, 12'h000, '0);
      chk("err_bits", rd, 32'h05);
      apb(0, 12'h000, '0);
      chk("err_clr", rd, 32'h0);
      $display("test command done");
   endtask : t_cmd
   // enter ignored until gated, then buffer store, low load and peek
   task automatic t_panel();
      @(posedge pclk);
      sw.options <= 7'h7F;
      sw.load_target <= `MPS_LOAD_BUF;
      sw.bus_out <= 9'h15A;
      pm_u.press(0);
      apb(0, 12'h010, '0);
      chk("gated", rd[11:0], 0);
      ev.machine_disabled <= 1'b1;
      sw.key_service <= 1'b1;
      pm_u.press(0);
      apb(0, 12'h010, '0);
      chk("buf_bac", rd[11:0], 1);
      sw.load_target <= `MPS_LOAD_LO;
      sw.bus_out <= 9'h100;
      pm_u.press(0);
      apb(0, 12'h010, '0);
      chk("lo_bac", rd[11:0], 0);
      pm_u.press(2);
      apb(0, 12'h010, '0);
      chk("peek", {rd[31:24], rd[11:0]}, 20'h5A001);
      chk("features", feature_on, 7'h7F);
      sw.free_run <= 1'b0;
      repeat (4) @(posedge pclk);
      tp_cnt = 0;
      pm_u.press(1);
      chk("step", tp_cnt, 1);
      chk("no_stop", check_stop, 0);
      sw.load_target <= `MPS_LOAD_REG;
      sw.bus_out <= 9'h0C1;
      pm_u.press(0);
      chk("glyph", glyph_code, 8'hC1);
      pm_u.press(3);
      chk("stroke", glyph_stroke, 1);
      $display("test panel done");
   endtask : t_panel
   task automatic t_events();
      ev.pen_hit <= 1'b1;
      ev.char_mode <= 1'b1;
      @(posedge pclk);
      ev.pen_hit <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(0, 12'h008, '0);
      chk("pen_fault", rd[6], 1);
      apb(0, 12'h004, '0);
      chk("mode", rd[2:0], 3'b101);
      ev.char_mode <= 1'b0;
      ev.service_req <= 1'b1;
      @(posedge pclk);
      ev.service_req <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(0, 12'h004, '0);
      chk("mode_held", rd[2:0], 3'b100);
      apb(0, 12'h004, '0);
      chk("mode_clr", rd[2:0], 0);
      apb(0, 12'h008, '0);
      chk("attn", rd[0], 1);
      $display("test events done");
   endtask : t_events
   // exempt controls work with the gate closed
   task automatic t_misc();
      ev.machine_disabled <= 1'b0;
      sw.lamp_test <= 1'b1;
      sw.options <= 7'h05;
      sw.power_remote <= 1'b1;
      ev.power_contact <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("lamps", {lamps_hi, lamps_lo}, 20'hFFFFF);
      chk("feat_off", feature_on, 7'h05);
      chk("pwr_remote", power_on, 1);
      ev.power_contact <= 1'b0;
      sw.lamp_test <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("pwr_drop", power_on, 0);
      sw.power_remote <= 1'b0;
      pm_u.press(5);
      chk("pwr_local", power_on, 1);
      pm_u.press(4);
      apb(0, 12'h010, '0);
      chk("clear_view", rd, 0);
      chk("clear_cmd", cmd_decode, 0);
      chk("clear_stroke", glyph_stroke, 0);
      chk("clear_glyph", glyph_code, 0);
      chk("clear_idx_ok", tp_index < 5'h10, 1);
      $display("test misc done");
   endtask : t_misc
   // main sequence after a 12-cycle reset
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_cmd();
      t_panel();
      t_events();
      t_misc();
      finish_test();
   end
   // hang guard
   initial begin
      #2000000;
      fails++;
      finish_test();
   end
endmodule : tb
